// [logic/johc_ctrl.sv]
`timescale 1ns/1ps
module johc_ctrl
  import johc_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_rst,
  input  wire logic [OP_W-1:0]   i_instr,
  input  wire logic [DATA_W-1:0] i_data,
  input  wire logic              i_cond_true,
  input  wire logic [IRQ_N-1:0]  i_irq_req,
  input  wire logic [IRQ_N-1:0]  i_irq_mask,
  input  wire logic              i_irq_in_progress_flag_clr,
  output logic [DATA_W-1:0]      o_addr,
  output logic                   o_addr_oe_n,
  output johc_width_t            o_offset_width,
  output logic                   o_hold_mode,
  output logic [IRQ_N-1:0]       o_irq_latch,
  output logic                   o_irq_enabled,
  output logic                   o_irq_in_progress,
  output logic                   o_vector_req
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [IRQ_N-1:0] sync1_r;
  logic [IRQ_N-1:0] irq_s_r;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sync1_r <= '0;
      irq_s_r <= '0;
    end else begin
      sync1_r <= i_irq_req;
      irq_s_r <= sync1_r;
    end
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [DATA_W-1:0] pc_r;
  logic [DATA_W-1:0] pc_nxt;
  logic [OP_W-1:0]   instr_r;
  logic [OP_W-1:0]   instr_nxt;
  johc_width_t       width_r;
  johc_width_t       width_nxt;
  logic              hold_rpt_r;
  logic              hold_rpt_nxt;
  logic              float_r;
  logic              float_nxt;
  logic [IRQ_N-1:0]  latch_r;
  logic [IRQ_N-1:0]  latch_nxt;
  logic              ena_r;
  logic              ena_nxt;
  logic              irq_in_progress_flag_r;
  logic              irq_in_progress_flag_nxt;
  logic              vec_r;
  logic              vec_nxt;

  logic [OP_W-1:0]   exec;
  johc_dec_t         dec;
  logic [DATA_W-1:0] offset;
  logic [DATA_W-1:0] pc_inc;
  logic [DATA_W-1:0] target;
  logic              take;

  // ----------------------------------------
  // Decode and next state
  // ----------------------------------------
  always_comb begin
    // Repeat the held instruction; the port is ignored meanwhile
    exec = hold_rpt_r ? instr_r : i_instr; // see [RULE8]
    dec  = '0;
    dec.width = width_r;
    case (exec)
      OP_SEL_FULL: begin
        dec.sel_width = 1'b1;
        dec.width     = JOHC_WID_FULL; // see [RULE1]
      end
      OP_SEL_TWLV: begin
        dec.sel_width = 1'b1;
        dec.width     = JOHC_WID_TWLV; // see [RULE2]
      end
      OP_SEL_BYTE: begin
        dec.sel_width = 1'b1;
        dec.width     = JOHC_WID_BYTE; // see [RULE4]
      end
      OP_HOLD_SEL: begin
        dec.sel_width = 1'b1;
        dec.width     = JOHC_WID_HOLD; // see [RULE6]
      end
      OP_IDLE:     dec.idle        = 1'b1;
      OP_CLR_IRQS: dec.irq_clear   = 1'b1;
      OP_ENA_IRQS: dec.irq_enable  = 1'b1;
      OP_DIS_IRQS: dec.irq_disable = 1'b1;
      default: begin
        dec.rel_jump = (exec[6:4] == REL_GRP) &&
                       ((exec[1:0] == REL_JUMP_LO) || (exec[1:0] == REL_CALL_LO));
      end
    endcase

    case (width_r)
      JOHC_WID_FULL: offset = i_data; // see [RULE1]
      JOHC_WID_TWLV: offset = {{4{i_data[11]}}, i_data[11:0]}; // see [RULE2] [RULE3]
      default:       offset = {{8{i_data[7]}}, i_data[7:0]}; // see [RULE3] [RULE4] [RULE6]
    endcase
    pc_inc = pc_r + 16'h0001;
    target = pc_inc + offset; // see [RULE5]

    // Only width selects touch the field, so hold mode persists until one
    width_nxt    = dec.sel_width ? dec.width : width_r; // see [RULE7]
    hold_rpt_nxt = (width_r == JOHC_WID_HOLD) && irq_s_r[HOLD_IRQ]; // see [RULE8]
    instr_nxt    = exec;

    // Unheld idle after a floated idle drives the next address instead
    float_nxt = dec.idle && (hold_rpt_r || !float_r); // see [RULE12] [RULE13]
    if (float_nxt) begin
      pc_nxt = pc_r; // see [RULE12]
    end else if (dec.rel_jump && i_cond_true) begin
      pc_nxt = target; // see [RULE5]
    end else begin
      pc_nxt = pc_inc; // see [RULE10]
    end

    // New requests win over the clear-all op
    latch_nxt = (dec.irq_clear ? '0 : latch_r) | irq_s_r; // see [RULE17] [RULE18]
    ena_nxt   = dec.irq_enable ? 1'b1 : (dec.irq_disable ? 1'b0 : ena_r);
    take      = ena_r && !irq_in_progress_flag_r && (|(latch_r & ~i_irq_mask));
    irq_in_progress_flag_nxt  = take || (irq_in_progress_flag_r && !i_irq_in_progress_flag_clr); // see [RULE15]
    // No vector can leave a floated port
    vec_nxt   = take && !float_nxt; // see [RULE15]
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pc_r       <= '0;
      instr_r    <= OP_ADVANCE;
      width_r    <= WIDTH_RESET;
      hold_rpt_r <= 1'b0;
      float_r    <= 1'b0;
      latch_r    <= '0;
      ena_r      <= IRQ_ENA_RST;
      irq_in_progress_flag_r     <= 1'b0;
      vec_r      <= 1'b0;
    end else begin
      pc_r       <= pc_nxt;
      instr_r    <= instr_nxt;
      width_r    <= width_nxt;
      hold_rpt_r <= hold_rpt_nxt;
      float_r    <= float_nxt;
      latch_r    <= latch_nxt;
      ena_r      <= ena_nxt;
      irq_in_progress_flag_r     <= irq_in_progress_flag_nxt;
      vec_r      <= vec_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_addr            = pc_r;
  assign o_addr_oe_n       = float_r;
  assign o_offset_width    = width_r;
  assign o_hold_mode       = (width_r == JOHC_WID_HOLD);
  assign o_irq_latch       = latch_r;
  assign o_irq_enabled     = ena_r;
  assign o_irq_in_progress = irq_in_progress_flag_r;
  assign o_vector_req      = vec_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  sequence unheld_idle;
    dec.idle && !hold_rpt_r;
  endsequence

  full_select_a: assert property (exec == OP_SEL_FULL |=> o_offset_width == JOHC_WID_FULL) // see [RULE1]
    else $error("full width select not stored");
  twelve_select_a: assert property (exec == OP_SEL_TWLV |=> o_offset_width == JOHC_WID_TWLV) // see [RULE2]
    else $error("twelve bit select not stored");
  byte_select_a: assert property (exec == OP_SEL_BYTE |=> o_offset_width == JOHC_WID_BYTE) // see [RULE4]
    else $error("byte select not stored");
  hold_select_a: assert property (exec == OP_HOLD_SEL |=> o_hold_mode && !o_offset_width[0]) // see [RULE6]
    else $error("hold mode not entered");
  sign_extend_a: assert property (width_r != JOHC_WID_FULL |->
    offset[15:7] == {9{offset[7]}} || (width_r == JOHC_WID_TWLV && offset[15:11] == {5{i_data[11]}})) // see [RULE3]
    else $error("offset not sign extended");
  width_keep_a: assert property (!dec.sel_width |=> $stable(o_offset_width)) // see [RULE7]
    else $error("offset field changed without a select");
  jump_target_a: assert property (dec.rel_jump && i_cond_true && !dec.idle
    |=> o_addr == $past(pc_r) + 16'h0001 + $past(offset)) // see [RULE5]
    else $error("relative jump target wrong");
  hold_repeat_a: assert property (hold_rpt_r |-> exec == $past(exec)) // see [RULE8]
    else $error("held instruction not repeated");
  advance_op_a: assert property (exec == OP_ADVANCE |=> o_addr == $past(pc_r) + 16'h0001 && !o_addr_oe_n) // see [RULE10]
    else $error("advance op misbehaved");
  idle_float_a: assert property (unheld_idle and !float_r |=> o_addr_oe_n && $stable(o_addr)) // see [RULE12]
    else $error("idle did not float the port");
  idle_alternate_a: assert property (unheld_idle ##1 unheld_idle |=> o_addr_oe_n != $past(o_addr_oe_n)) // see [RULE13]
    else $error("repeated idle did not alternate");
  idle_irq_a: assert property (take && float_nxt |=> o_irq_in_progress && !o_vector_req) // see [RULE15]
    else $error("idle interrupt handled wrongly");
  irq_capture_a: assert property (1'b1 |=> (o_irq_latch & $past(irq_s_r)) == $past(irq_s_r)) // see [RULE17]
    else $error("request not latched");
  clear_all_a: assert property (dec.irq_clear && irq_s_r == '0 |=> o_irq_latch == '0) // see [RULE18]
    else $error("clear-all left latch set");

endmodule

// [logic/johc_pkg.sv]
// What this block does
// [RULE1] Full-width select writes 00 to offset field; jumps use all sixteen data bits.
// [RULE2] Twelve-bit select writes 11; jumps use data bits 11-0 only.
// [RULE3] Twelve- and eight-bit offsets are sign-extended to sixteen bits before adding.
// [RULE4] Byte select writes 01; jumps use data bits 7-0 only.
// [RULE5] Taken relative jump target is incremented counter plus adjusted offset.
// [RULE6] Hold-mode select writes 10, enabling hold mode with byte offsets.
// [RULE7] Hold mode ends only when a width select overwrites the offset field.
// [RULE8] In hold mode the hold line repeats the latched instruction until released.
// [RULE9] Outside logic never asserts hold together with the hold-mode select.
// [RULE10] Advance op only drives the counter out and increments it.
// [RULE11] Microcode starts every service routine with an advance op.
// [RULE12] Idle floats the address port and holds the counter for one cycle.
// [RULE13] Back-to-back idles without hold alternate float and next sequential address.
// [RULE14] Microcode repeats idle through hold mode to float the port longer.
// [RULE15] Interrupt taken during idle sets in-progress flag but issues no vector; code still issues one on an idle that does not float the port.
// [RULE16] Microcode inhibits interrupt processing while idle executes.
// [RULE17] Interrupt requests are still latched while processing is inhibited.
// [RULE18] Clear-all op clears the latch, including a hold-left line 1 bit.
package johc_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int unsigned DATA_W   = 16;
  localparam int unsigned IRQ_N    = 10;
  localparam int unsigned OP_W     = 7;
  localparam int unsigned HOLD_IRQ = 1;
  localparam int unsigned OWF_LSB  = 4;

  // ----------------------------------------
  // Opcodes
  // ----------------------------------------
  localparam logic [6:0] OP_ADVANCE   = 7'h00;
  localparam logic [6:0] OP_IDLE      = 7'h10;
  localparam logic [6:0] OP_SEL_FULL  = 7'h24;
  localparam logic [6:0] OP_HOLD_SEL  = 7'h25;
  localparam logic [6:0] OP_SEL_BYTE  = 7'h26;
  localparam logic [6:0] OP_SEL_TWLV  = 7'h27;
  localparam logic [6:0] OP_CLR_IRQS  = 7'h01;
  localparam logic [6:0] OP_DIS_IRQS  = 7'h16;
  localparam logic [6:0] OP_ENA_IRQS  = 7'h36;
  localparam logic [2:0] REL_GRP      = 3'h7;
  localparam logic [1:0] REL_JUMP_LO  = 2'h1;
  localparam logic [1:0] REL_CALL_LO  = 2'h2;

  // ----------------------------------------
  // Offset width field and reset values
  // ----------------------------------------
  typedef enum logic [1:0] {
    JOHC_WID_FULL = 2'b00,
    JOHC_WID_BYTE = 2'b01,
    JOHC_WID_HOLD = 2'b10,
    JOHC_WID_TWLV = 2'b11
  } johc_width_t;

  localparam johc_width_t WIDTH_RESET = JOHC_WID_FULL;
  localparam logic        IRQ_ENA_RST = 1'b0;

  typedef struct packed {
    logic        sel_width;
    johc_width_t width;
    logic        idle;
    logic        rel_jump;
    logic        irq_clear;
    logic        irq_enable;
    logic        irq_disable;
  } johc_dec_t;

endpackage

// [verif/johc_hold_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// External hold request logic
// ----------------------------------------
module johc_hold_model (
  input  wire logic i_mclk,
  input  wire logic i_hold_cmd,
  output logic      o_hold_line
);
  // Registered on the rising edge so the line never races the command
  initial begin
    o_hold_line = 1'b0;
    forever @(posedge i_mclk) o_hold_line <= i_hold_cmd;
  end
endmodule

// [verif/jump_offset_and_hold_control_tb_top.sv]
`timescale 1ns/1ps
module jump_offset_and_hold_control_tb_top
  import johc_pkg::*;
;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic              i_mclk      = 1'b0;
  logic              i_rst       = 1'b1;
  logic              i_cond_true = 1'b0;
  logic              i_irq_in_progress_flag_clr  = 1'b0;
  logic              hold_cmd    = 1'b0;
  logic [OP_W-1:0]   i_instr     = OP_ADVANCE;
  logic [DATA_W-1:0] i_data      = 16'h0000;
  logic [IRQ_N-1:0]  i_irq_mask  = 10'h3FF;
  logic [IRQ_N-1:0]  other_req   = 10'h000;
  logic [IRQ_N-1:0]  i_irq_req;
  logic              hold_line;
  logic [DATA_W-1:0] o_addr;
  logic              o_addr_oe_n;
  johc_width_t       o_offset_width;
  logic              o_hold_mode;
  logic [IRQ_N-1:0]  o_irq_latch;
  logic              o_irq_enabled;
  logic              o_irq_in_progress;
  logic              o_vector_req;
  int                miscompares = 0;
  int                checks      = 0;
  int                cycles      = 0;
  logic [15:0]       pc          = 16'h0000;
  logic [15:0]       off;
  johc_width_t       wm          = JOHC_WID_FULL;
  logic              last_idle   = 1'b0;
  logic [6:0]        sel_ops [4] = '{OP_SEL_FULL, OP_SEL_TWLV, OP_SEL_BYTE, OP_HOLD_SEL};

  assign i_irq_req = {other_req[9:2], hold_line, other_req[0]};
  always #4 i_mclk = ~i_mclk;

  johc_hold_model johc_hold_model_inst (.i_mclk(i_mclk), .i_hold_cmd(hold_cmd),
    .o_hold_line(hold_line));
  johc_ctrl johc_ctrl_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_instr(i_instr),
    .i_data(i_data), .i_cond_true(i_cond_true), .i_irq_req(i_irq_req),
    .i_irq_mask(i_irq_mask), .i_irq_in_progress_flag_clr(i_irq_in_progress_flag_clr), .o_addr(o_addr),
    .o_addr_oe_n(o_addr_oe_n), .o_offset_width(o_offset_width),
    .o_hold_mode(o_hold_mode), .o_irq_latch(o_irq_latch), .o_irq_enabled(o_irq_enabled),
    .o_irq_in_progress(o_irq_in_progress), .o_vector_req(o_vector_req));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task conclude;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task chk16(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One instruction per cycle; expected counter tracked from the opcode
  task step(input logic [6:0] op, input logic [15:0] d, input logic c);
    i_instr     = op;
    i_data      = d;
    i_cond_true = c;
    @(negedge i_mclk);
    case (wm)
      JOHC_WID_FULL: off = d;
      JOHC_WID_TWLV: off = {{4{d[11]}}, d[11:0]};
      default:       off = {{8{d[7]}}, d[7:0]};
    endcase
    if (op == OP_IDLE && !last_idle) pc = pc;
    else if (op[6:4] == REL_GRP && op[1:0] inside {REL_JUMP_LO, REL_CALL_LO} && c)
      pc = pc + 16'h0001 + off;
    else pc = pc + 16'h0001;
    last_idle = (op == OP_IDLE) && !last_idle;
    case (op)
      OP_SEL_FULL: wm = JOHC_WID_FULL;
      OP_SEL_TWLV: wm = JOHC_WID_TWLV;
      OP_SEL_BYTE: wm = JOHC_WID_BYTE;
      OP_HOLD_SEL: wm = JOHC_WID_HOLD;
      default: ;
    endcase
  endtask

  // Sync stages make the hold path slow; ceiling leaves ample margin
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 500) begin
      miscompares++;
      conclude();
    end
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (4) @(negedge i_mclk);
    i_rst = 1'b0;
    chk16(o_addr, 16'h0000);
    chk16({14'h0000, o_offset_width}, 16'h0000);
    chk1(o_irq_enabled, 1'b0);
    for (int k = 0; k < 4; k++) begin
      step(sel_ops[k], 16'h0000, 1'b0);
      chk16({14'h0000, o_offset_width}, {14'h0000, wm});
      chk1(o_hold_mode, wm == JOHC_WID_HOLD);
      step(7'h79, 16'hE3C0, 1'b1);
      chk16(o_addr, pc);
      step(7'h7A, 16'h0800, 1'b1);
      chk16(o_addr, pc);
    end
    step(OP_SEL_BYTE, 16'h0000, 1'b0);
    chk16({14'h0000, o_offset_width}, 16'h0001);
    chk1(o_hold_mode, 1'b0);
    step(7'h79, 16'h1234, 1'b0);
    chk16(o_addr, pc);
    step(OP_ADVANCE, 16'h0000, 1'b0);
    chk16(o_addr, pc);
    chk1(o_addr_oe_n, 1'b0);
    step(OP_IDLE, 16'h0000, 1'b0);
    chk1(o_addr_oe_n, 1'b1);
    chk16(o_addr, pc);
    step(OP_IDLE, 16'h0000, 1'b0);
    chk1(o_addr_oe_n, 1'b0);
    chk16(o_addr, pc);
    step(OP_HOLD_SEL, 16'h0000, 1'b0);
    // Hold raised only after the select ran; interrupts still off from reset
    hold_cmd = 1'b1;
    repeat (6) step(OP_IDLE, 16'h0000, 1'b0);
    repeat (4) begin
      step(OP_ADVANCE, 16'h0000, 1'b0);
      chk1(o_addr_oe_n, 1'b1);
    end
    chk1(o_hold_mode, 1'b1);
    hold_cmd = 1'b0;
    repeat (4) step(OP_IDLE, 16'h0000, 1'b0);
    step(OP_SEL_FULL, 16'h0000, 1'b0);
    chk1(o_hold_mode, 1'b0);
    chk1(o_irq_latch[1], 1'b1);
    chk1(o_irq_in_progress, 1'b0);
    step(OP_CLR_IRQS, 16'h0000, 1'b0);
    chk16({6'h00, o_irq_latch}, 16'h0000);
    other_req = 10'h008;
    repeat (3) step(OP_ADVANCE, 16'h0000, 1'b0);
    chk1(o_irq_latch[3], 1'b1);
    chk1(o_irq_in_progress, 1'b0);
    step(OP_ENA_IRQS, 16'h0000, 1'b0);
    chk1(o_irq_enabled, 1'b1);
    // Unmasked before idle so the take lands on the floated cycle
    i_irq_mask = 10'h000;
    step(OP_IDLE, 16'h0000, 1'b0);
    chk1(o_addr_oe_n, 1'b1);
    chk1(o_irq_in_progress, 1'b1);
    chk1(o_vector_req, 1'b0);
    step(OP_ADVANCE, 16'h0000, 1'b0);
    chk1(o_irq_in_progress, 1'b1);
    chk1(o_vector_req, 1'b0);
    i_irq_in_progress_flag_clr = 1'b1;
    step(OP_ADVANCE, 16'h0000, 1'b0);
    chk1(o_irq_in_progress, 1'b0);
    i_irq_in_progress_flag_clr = 1'b0;
    step(OP_ADVANCE, 16'h0000, 1'b0);
    chk1(o_vector_req, 1'b1);
    chk1(o_irq_in_progress, 1'b1);
    step(OP_ADVANCE, 16'h0000, 1'b0);
    chk1(o_vector_req, 1'b0);
    step(OP_DIS_IRQS, 16'h0000, 1'b0);
    chk1(o_irq_enabled, 1'b0);
    i_irq_in_progress_flag_clr = 1'b1;
    step(OP_ADVANCE, 16'h0000, 1'b0);
    i_irq_in_progress_flag_clr = 1'b0;
    step(OP_IDLE, 16'h0000, 1'b0);
    chk1(o_irq_in_progress, 1'b0);
    chk1(o_irq_latch[3], 1'b1);
    conclude();
  end
endmodule
